// file: logic/sbr_device.sv
// Notes on behaviour
// R01 - Commands are sixteen bits, two bytes.
// R02 - First byte: seven-bit address plus access bit.
// R03 - Data bits 0..7 ride command bits 8..15.
// R04 - Access bit zero reads without writing.
// R05 - Access bit one writes the data byte.
// R06 - One address selects one whole byte register.
// R07 - Reset loads defined reset contents everywhere.
// R08 - Restart reloads, don't-care bits keep value.
// R09 - Read-only and reserved bits ignore writes.
// R10 - Plain read/write bits store written values.
// R11 - Hardware-modifiable bits accept writes and hardware.
// R12 - Reserved bits always read zero.
// R13 - Controller writes zero into reserved bits.
// R14 - Ordinary control bits never change by themselves.
// R15 - Controller alone changes ordinary control bits.
// R16 - Mode field: normal, sleep, stop, soft reset.
// R17 - Write returns the previously programmed value.
// R18 - Address bits 6..0, access bit 7, data 15..8.
// R19 - Status flags stick until a clearing access.
// R20 - Unmapped address: no change, reads zero.
`timescale 1ns/1ns
`default_nettype none
module sbr_device (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    sbr_link_if.device link,
    input wire logic restart_in,
    input wire logic hw_mode_normal_in,
    input wire logic hw_supply2_off_in,
    input wire logic hw_fail_out_set_in,
    input wire logic [7:0] evt_supply_b_in,
    input wire logic [7:0] evt_supply_a_in,
    input wire logic [7:0] evt_thermal_in,
    input wire logic [7:0] evt_device_in,
    input wire logic [7:0] evt_trx_in,
    input wire logic [7:0] evt_wake_a_in,
    input wire logic [7:0] evt_wake_b_in,
    input wire logic [7:0] evt_sw_ovl_in,
    input wire logic [7:0] evt_sw_ol_in,
    input wire logic [7:0] input_level_in,
    input wire logic [7:0] part_identity_in,
    output logic [1:0] sbc_mode_out,
    output logic soft_reset_out,
    output logic soft_reset_pin_pulse_option_out,
    output logic [7:0] ctrl_bytes_out [16]
);
    localparam int NCTL = 16;
    localparam int NST = 9;
    localparam logic [6:0] CA [NCTL] = '{sbr_pkg::A_MODE_SUPPLY_CONTROL, sbr_pkg::A_HARDWARE_CONFIG,
        sbr_pkg::A_WATCHDOG_CONFIG, sbr_pkg::A_TRANSCEIVER_MODE, sbr_pkg::A_TRANSCEIVER_OPTION,
        sbr_pkg::A_WAKE_SOURCE_ENABLE, sbr_pkg::A_WAKE_INPUT_PULL_CONFIG, sbr_pkg::A_PERIODIC_TIMER_ONE,
        sbr_pkg::A_PERIODIC_TIMER_TWO, sbr_pkg::A_SWITCH_SHUTDOWN_CONFIG, sbr_pkg::A_HIGH_SIDE_SELECT_A,
        sbr_pkg::A_HIGH_SIDE_SELECT_B, sbr_pkg::A_GENERAL_PIN_CONFIG, sbr_pkg::A_PULSE_WIDTH_DUTY_ONE,
        sbr_pkg::A_PULSE_WIDTH_DUTY_TWO, sbr_pkg::A_SCRATCH_SYSTEM_BYTE};
    localparam logic [7:0] CM [NCTL] = '{sbr_pkg::WM_MODE_SUPPLY, sbr_pkg::WM_HW_CONFIG,
        sbr_pkg::WM_WATCHDOG, sbr_pkg::WM_TRX_MODE, sbr_pkg::WM_TRX_OPTION, sbr_pkg::WM_WAKE_EN,
        sbr_pkg::WM_PULL, sbr_pkg::WM_TIMER, sbr_pkg::WM_TIMER, sbr_pkg::WM_SW_SD, sbr_pkg::WM_HS,
        sbr_pkg::WM_HS, sbr_pkg::WM_ALL, sbr_pkg::WM_ALL, sbr_pkg::WM_ALL, sbr_pkg::WM_ALL};
    localparam logic [6:0] SA [NST] = '{sbr_pkg::A_SUPPLY_FLAGS_B, sbr_pkg::A_SUPPLY_FLAGS_A,
        sbr_pkg::A_THERMAL_FLAGS, sbr_pkg::A_DEVICE_FLAGS, sbr_pkg::A_TRANSCEIVER_FLAGS,
        sbr_pkg::A_WAKE_EVENT_FLAGS_A, sbr_pkg::A_WAKE_EVENT_FLAGS_B, sbr_pkg::A_SWITCH_OVERLOAD_FLAGS,
        sbr_pkg::A_SWITCH_OPEN_LOAD_FLAGS};

    logic [7:0] ctl_r [NCTL];
    logic [7:0] st_r [NST];
    logic [7:0] evt [NST];
    logic [7:0] rd_data;
    logic [6:0] addr;
    logic wr;
    logic soft_rst;

    assign addr = link.cmd_word[sbr_pkg::ADDR_W-1:0]; // R02 R18
    assign wr = link.cmd_word[sbr_pkg::POS_ACC]; // R04 R05
    assign evt = '{evt_supply_b_in, evt_supply_a_in, evt_thermal_in, evt_device_in, evt_trx_in,
        evt_wake_a_in, evt_wake_b_in, evt_sw_ovl_in, evt_sw_ol_in};
    // A written mode of 11 triggers a soft reset on the following cycle.
    assign soft_rst = (ctl_r[0][7:6] == sbr_pkg::MODE_SOFT_RESET); // R16
    assign sbc_mode_out = ctl_r[0][7:6];
    assign soft_reset_out = soft_rst;
    assign soft_reset_pin_pulse_option_out = ctl_r[1][sbr_pkg::SOFT_RESET_PIN_POS];
    assign ctrl_bytes_out = ctl_r;

    // Read data is the current content, captured before any write lands.
    always_comb begin
        rd_data = 8'h00; // R20
        for (int i = 0; i < NCTL; i++) begin
            if (addr == CA[i]) begin
                rd_data = ctl_r[i] & CM[i]; // R06 R12 R17
            end
        end
        for (int i = 0; i < NST; i++) begin
            if (addr == SA[i]) begin
                rd_data = st_r[i];
            end
        end
        if (addr == sbr_pkg::A_INPUT_LEVEL_STATE) begin
            rd_data = input_level_in;
        end
        if (addr == sbr_pkg::A_PART_IDENTITY) begin
            rd_data = part_identity_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < NCTL; i++) begin
                ctl_r[i] <= sbr_pkg::RST_VALUE; // R07
            end
        end else if (clk_en_in) begin
            if (soft_rst) begin
                for (int i = 0; i < NCTL; i++) begin
                    ctl_r[i] <= sbr_pkg::RST_VALUE; // R07
                end
            end else if (restart_in) begin
                ctl_r[0] <= ctl_r[0] & sbr_pkg::KEEP_MODE_SUPPLY; // R08
                ctl_r[1] <= ctl_r[1] & sbr_pkg::KEEP_HW_CONFIG; // R08
            end else begin
                for (int i = 0; i < NCTL; i++) begin
                    if (link.cmd_valid && wr && addr == CA[i]) begin
                        ctl_r[i] <= link.cmd_word[15:8] & CM[i]; // R03 R09 R10 R13 R14
                    end
                end
                // Hardware updates on rwh bits follow any write in the same cycle.
                if (hw_mode_normal_in) begin
                    ctl_r[0][7:6] <= sbr_pkg::MODE_NORMAL; // R11
                end
                if (hw_supply2_off_in) begin
                    ctl_r[0][4:3] <= 2'h0; // R11
                end
                if (hw_fail_out_set_in) begin
                    ctl_r[1][5] <= 1'b1; // R11
                end
            end
        end
    end

    // Any access to a flag register clears it; new events win over the clear.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < NST; i++) begin
                st_r[i] <= sbr_pkg::RST_VALUE;
            end
        end else if (clk_en_in) begin
            for (int i = 0; i < NST; i++) begin
                if (link.cmd_valid && addr == SA[i]) begin
                    st_r[i] <= evt[i]; // R19
                end else begin
                    st_r[i] <= st_r[i] | evt[i]; // R19
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link.rsp_valid <= 1'b0;
            link.rsp_data <= 8'h00;
        end else if (clk_en_in) begin
            link.rsp_valid <= link.cmd_valid; // R01
            if (link.cmd_valid) begin
                link.rsp_data <= rd_data; // R04 R17
            end
        end
    end
endmodule : sbr_device
`default_nettype wire

// file: shared/sbr_pkg.sv
package sbr_pkg;
    localparam int CMD_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int POS_ACC = 7;
    localparam int POS_DLO = 8;
    localparam int NREG = 128;
    localparam logic [6:0] A_MODE_SUPPLY_CONTROL = 7'h01;
    localparam logic [6:0] A_HARDWARE_CONFIG = 7'h02;
    localparam logic [6:0] A_WATCHDOG_CONFIG = 7'h03;
    localparam logic [6:0] A_TRANSCEIVER_MODE = 7'h04;
    localparam logic [6:0] A_TRANSCEIVER_OPTION = 7'h05;
    localparam logic [6:0] A_WAKE_SOURCE_ENABLE = 7'h06;
    localparam logic [6:0] A_WAKE_INPUT_PULL_CONFIG = 7'h08;
    localparam logic [6:0] A_PERIODIC_TIMER_ONE = 7'h0C;
    localparam logic [6:0] A_PERIODIC_TIMER_TWO = 7'h0D;
    localparam logic [6:0] A_SWITCH_SHUTDOWN_CONFIG = 7'h10;
    localparam logic [6:0] A_HIGH_SIDE_SELECT_A = 7'h14;
    localparam logic [6:0] A_HIGH_SIDE_SELECT_B = 7'h15;
    localparam logic [6:0] A_GENERAL_PIN_CONFIG = 7'h17;
    localparam logic [6:0] A_PULSE_WIDTH_DUTY_ONE = 7'h18;
    localparam logic [6:0] A_PULSE_WIDTH_DUTY_TWO = 7'h19;
    localparam logic [6:0] A_SCRATCH_SYSTEM_BYTE = 7'h1E;
    localparam logic [6:0] A_SUPPLY_FLAGS_B = 7'h40;
    localparam logic [6:0] A_SUPPLY_FLAGS_A = 7'h41;
    localparam logic [6:0] A_THERMAL_FLAGS = 7'h42;
    localparam logic [6:0] A_DEVICE_FLAGS = 7'h43;
    localparam logic [6:0] A_TRANSCEIVER_FLAGS = 7'h44;
    localparam logic [6:0] A_WAKE_EVENT_FLAGS_A = 7'h46;
    localparam logic [6:0] A_WAKE_EVENT_FLAGS_B = 7'h47;
    localparam logic [6:0] A_INPUT_LEVEL_STATE = 7'h48;
    localparam logic [6:0] A_SWITCH_OVERLOAD_FLAGS = 7'h54;
    localparam logic [6:0] A_SWITCH_OPEN_LOAD_FLAGS = 7'h55;
    localparam logic [6:0] A_PART_IDENTITY = 7'h7E;
    localparam logic [7:0] RST_VALUE = 8'h00;
    // Writable-bit masks; zero bits are reserved or read-only.
    localparam logic [7:0] WM_MODE_SUPPLY = 8'hFF;
    localparam logic [7:0] WM_HW_CONFIG = 8'hFB;
    localparam logic [7:0] WM_WATCHDOG = 8'hF7;
    localparam logic [7:0] WM_TRX_MODE = 8'h03;
    localparam logic [7:0] WM_TRX_OPTION = 8'h30;
    localparam logic [7:0] WM_WAKE_EN = 8'hE4;
    localparam logic [7:0] WM_PULL = 8'h7F;
    localparam logic [7:0] WM_TIMER = 8'h77;
    localparam logic [7:0] WM_SW_SD = 8'h70;
    localparam logic [7:0] WM_HS = 8'h77;
    localparam logic [7:0] WM_ALL = 8'hFF;
    // Restart-held masks: set bits keep their value on restart.
    localparam logic [7:0] KEEP_MODE_SUPPLY = 8'h23;
    localparam logic [7:0] KEEP_HW_CONFIG = 8'hD9;
    localparam logic [7:0] MODE_HI = 8'h80;
    localparam logic [7:0] MODE_LO = 8'h40;
    localparam logic [7:0] SUPPLY2_BITS = 8'h18;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
    localparam int SOFT_RESET_PIN_POS = 6;
endpackage : sbr_pkg

// file: shared/sbr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sbr_link_if;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic rsp_valid;
    logic [7:0] rsp_data;
    modport device (input cmd_valid, input cmd_word, output rsp_valid, output rsp_data);
    modport ctrl (output cmd_valid, output cmd_word, input rsp_valid, input rsp_data);
endinterface : sbr_link_if
`default_nettype wire

// file: logic/sbr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module sbr_ctrl (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    sbr_link_if.ctrl link,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [6:0] req_addr_in,
    input wire logic [7:0] req_data_in,
    input wire logic [7:0] req_rsvd_mask_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [7:0] rd_data_out
);
    logic busy_r;

    assign req_ready_out = !busy_r;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_r <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cmd_word <= 16'h0000;
        end else if (clk_en_in) begin
            link.cmd_valid <= 1'b0;
            if (!busy_r && req_valid_in) begin
                busy_r <= 1'b1;
                link.cmd_valid <= 1'b1;
                // Reserved positions are forced to zero before sending.
                link.cmd_word <= {req_data_in & ~req_rsvd_mask_in, req_write_in, req_addr_in}; // R01 R02 R03 R13 R15 R18
            end else if (link.rsp_valid) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_out <= 1'b0;
            rd_data_out <= 8'h00;
        end else if (clk_en_in) begin
            done_out <= link.rsp_valid && busy_r;
            if (link.rsp_valid && busy_r) begin
                rd_data_out <= link.rsp_data; // R04 R17
            end
        end
    end
endmodule : sbr_ctrl
`default_nettype wire

// file: tb/sbr_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sbr_link_properties (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    logic [7:0] scr_r;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // Shadow of the scratch byte, cleared again when a soft reset is commanded.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scr_r <= 8'h00;
        end else if (cmd_valid && cmd_word[7] && cmd_word[6:0] == sbr_pkg::A_SCRATCH_SYSTEM_BYTE) begin
            scr_r <= cmd_word[15:8];
        end else if (cmd_valid && cmd_word[7] && cmd_word[6:0] == 7'h01 && cmd_word[15:14] == 2'h3) begin
            scr_r <= 8'h00;
        end
    end
    sequence s_cmd_to(logic [6:0] a);
        cmd_valid && cmd_word[6:0] == a;
    endsequence
    sequence s_unmapped;
        cmd_valid && (cmd_word[6:0] == 7'h00 || cmd_word[6:0] == 7'h20 || cmd_word[6:0] == 7'h7F);
    endsequence
    a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid) else $error("no answer after command");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid)) else $error("answer without command");
    a_cmd_spacing: assert property (cmd_valid |=> !cmd_valid [*2]) else $error("commands too close");
    a_rsp_single: assert property (rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
    a_unmapped_zero: assert property (s_unmapped |=> rsp_data == 8'h00) else $error("unmapped read not zero");
    a_rsvd_reads_zero: assert property (s_cmd_to(sbr_pkg::A_TRANSCEIVER_MODE) |=> rsp_data[7:2] == 6'h00)
        else $error("reserved bits not zero");
    a_write_old_value: assert property (s_cmd_to(sbr_pkg::A_SCRATCH_SYSTEM_BYTE) |=> rsp_data == $past(scr_r))
        else $error("scratch answer not previous value");
    a_rsp_data_holds: assert property (!rsp_valid |-> $stable(rsp_data)) else $error("answer data moved");
endmodule : sbr_link_properties
`default_nettype wire

// file: tb/sbr_spi_register_bank_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sbr_spi_register_bank_tb_top;
    localparam logic [6:0] CTRL_A [16] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h08, 7'h0C, 7'h0D, 7'h10,
        7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1E};
    localparam logic [7:0] WM [16] = '{8'hFF, 8'hFB, 8'hF7, 8'h03, 8'h30, 8'hE4, 8'h7F, 8'h77, 8'h77, 8'h70,
        8'h77, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [6:0] FLAG_A [9] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
    localparam logic [6:0] ODD_A [6] = '{7'h00, 7'h07, 7'h20, 7'h48, 7'h7E, 7'h7F};
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic restart = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_data = 8'h00;
    logic [7:0] evt [9] = '{default: 8'h00};
    logic [7:0] lvl = 8'h00;
    logic [7:0] ident = 8'h5A;
    logic done;
    logic [1:0] mode;
    logic [7:0] rd_data;
    logic [7:0] ctrl_bytes [16];
    logic [7:0] mdl [128] = '{default: 8'h00};
    logic [6:0] a;
    logic [7:0] d;
    int err_total = 0;
    int samples_checked = 0;
    sbr_link_if lnk();
    sbr_device i_sbr_device (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1), .link(lnk),
        .restart_in(restart), .hw_mode_normal_in(1'b0), .hw_supply2_off_in(1'b0), .hw_fail_out_set_in(1'b0),
        .evt_supply_b_in(evt[0]), .evt_supply_a_in(evt[1]), .evt_thermal_in(evt[2]), .evt_device_in(evt[3]),
        .evt_trx_in(evt[4]), .evt_wake_a_in(evt[5]), .evt_wake_b_in(evt[6]), .evt_sw_ovl_in(evt[7]),
        .evt_sw_ol_in(evt[8]), .input_level_in(lvl), .part_identity_in(ident), .sbc_mode_out(mode),
        .soft_reset_out(), .soft_reset_pin_pulse_option_out(), .ctrl_bytes_out(ctrl_bytes));
    sbr_ctrl i_sbr_ctrl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1), .link(lnk),
        .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr), .req_data_in(req_data),
        .req_rsvd_mask_in(8'h00), .req_ready_out(), .done_out(done), .rd_data_out(rd_data));
    sbr_link_properties u_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cmd_valid(lnk.cmd_valid),
        .cmd_word(lnk.cmd_word), .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));
    initial forever #25 mclk_in = ~mclk_in;
    function automatic logic [7:0] wmask(logic [6:0] x);
        foreach (CTRL_A[i]) if (CTRL_A[i] == x) return WM[i];
        return 8'h00;
    endfunction : wmask
    task automatic cmp8(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic report_and_stop();
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic xfer(bit wr, logic [6:0] x, logic [7:0] v);
        int n;
        logic [7:0] e;
        logic [7:0] m;
        e = (x == 7'h48) ? lvl : (x == 7'h7E) ? ident : mdl[x];
        m = wmask(x);
        @(posedge mclk_in);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= x;
        req_data <= v;
        @(posedge mclk_in);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        if (n >= 20) report_and_stop();
        cmp8(rd_data, e);
        if (wr) mdl[x] = (mdl[x] & ~m) | (v & m);
        if (m == 8'h00) mdl[x] = 8'h00;
        if (wr && x == 7'h01 && v[7:6] == 2'h3) foreach (CTRL_A[i]) mdl[CTRL_A[i]] = 8'h00;
    endtask : xfer
    task automatic pulse_evt(int i, logic [7:0] v);
        @(posedge mclk_in);
        evt[i] <= v;
        @(posedge mclk_in);
        evt[i] <= 8'h00;
        mdl[FLAG_A[i]] = mdl[FLAG_A[i]] | v;
    endtask : pulse_evt
    initial begin
        void'($urandom(37875));
        repeat (6) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        lvl <= 8'($urandom);
        foreach (CTRL_A[i]) xfer(0, CTRL_A[i], 8'h00);
        xfer(1, 7'h1E, 8'hA5);
        pulse_evt(3, 8'h0C);
        for (int m = 0; m < 4; m++) begin
            xfer(1, 7'h01, {2'(m), 6'h00});
            if (m < 3) cmp8({6'h00, mode}, 8'(m));
        end
        foreach (CTRL_A[i]) xfer(0, CTRL_A[i], 8'h00);
        for (int k = 0; k < 90; k++) begin
            a = ($urandom % 4 < 2) ? CTRL_A[$urandom % 16] : ($urandom % 2) ? FLAG_A[$urandom % 9] : ODD_A[$urandom % 6];
            d = 8'($urandom);
            if (a == 7'h01) d[7] = 1'b0;
            if ($urandom % 3 == 0) pulse_evt($urandom % 9, 8'($urandom));
            xfer($urandom % 2, a, d);
        end
        foreach (CTRL_A[i]) cmp8(ctrl_bytes[i], mdl[CTRL_A[i]]);
        @(posedge mclk_in);
        restart <= 1'b1;
        @(posedge mclk_in);
        restart <= 1'b0;
        mdl[1] = mdl[1] & sbr_pkg::KEEP_MODE_SUPPLY;
        mdl[2] = mdl[2] & sbr_pkg::KEEP_HW_CONFIG;
        xfer(0, 7'h01, 8'h00);
        xfer(0, 7'h02, 8'h00);
        report_and_stop();
    end
endmodule : sbr_spi_register_bank_tb_top
`default_nettype wire
